//--- core/output_clock_select_config.sv
// output clock selection and pll frequency configuration with apb registers
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module output_clock_select_config
    import clk_sel_pkg::*;
(
    // clock, reset, enable
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [DATA_W-1:0] pwdata_in,
    output logic pready_out,
    output logic pslverr_out,
    output logic [DATA_W-1:0] prdata_out,
    // strap pin and main register context
    input wire logic rate_strap_in,
    input wire logic composite_t1e1_source_sel_in,
    input wire logic main_rate_sel_in,
    input wire logic aux_ref_valid_in,
    // fifth selector code from the register outside this block
    input wire logic [3:0] fifth_out_freq_sel_in,
    // fixed rate sources from same-clock logic
    input wire logic pulse_2k_in,
    input wire logic pulse_8k_in,
    input wire logic t1e1_clk_in,
    input wire logic composite_clk_in,
    // fixed rate outputs
    output logic pulse_2k_out,
    output logic pulse_8k_out,
    output logic t1e1_clk_out,
    output logic composite_clk_out,
    output logic composite_clk_oe_out,
    output logic t1e1_rate_out,
    output logic composite_duty_out,
    // general output selections
    output src_t fifth_src_out,
    output logic [DIV_W-1:0] fifth_div_out,
    output src_t seventh_src_out,
    output logic [DIV_W-1:0] seventh_div_out,
    // pll frequency settings
    output logic aux_dpll_en_out,
    output logic aux_measure_out,
    output logic aux_apll_from_main_out,
    output logic [KHZ_W-1:0] aux_dpll_khz_out,
    output logic [KHZ_W-1:0] aux_apll_khz_out,
    output logic main_dpll_en_out,
    output logic main_analog_fb_out,
    output logic [KHZ_W-1:0] main_dpll_khz_out,
    output logic [KHZ_W-1:0] main_apll_khz_out
);

    // software registers
    logic [7:0] output_config_four;
    logic [7:0] aux_pll_config_one;
    logic [7:0] main_pll_config_one;
    // fifth selector lives in a register outside this block
    logic [3:0] fifth_out_freq_sel;

    // named fields
    logic [3:0] seventh_out_freq_sel;
    logic pulse_2k_out_en;
    logic pulse_8k_out_en;
    logic t1e1_clk_out_en;
    logic composite_clk_out_en;
    logic auto_squelch_en;
    logic composite_duty_sel;
    logic t1e1_rate_sel;
    logic [3:0] aux_dpll_freq_sel;
    logic aux_measure_main_phase;
    logic aux_apll_from_main;
    logic [2:0] main_to_aux_freq_sel;
    logic [2:0] main_dpll_freq_sel;

    // strap synchroniser
    logic strap_meta;
    logic strap_s2;
    logic strap_s3;
    logic strap_level;
    logic next_strap_level;

    // apb decode
    logic setup_phase;
    logic access_phase;
    logic [ADDR_W-1:0] word_idx;
    logic hit_four;
    logic hit_aux;
    logic hit_main;
    logic addr_hit;
    logic [7:0] read_byte;

    // decoded values
    src_t fifth_src;
    src_t seventh_src;
    logic [DIV_W-1:0] fifth_div;
    logic [DIV_W-1:0] seventh_div;
    logic [KHZ_W-1:0] aux_khz;
    logic [KHZ_W-1:0] main_khz;
    logic [KHZ_W-1:0] m2a_khz;
    logic aux_path_on;
    logic squelch;
    logic t1e1_rate_eff;

    assign fifth_out_freq_sel = fifth_out_freq_sel_in;

    // field extraction
    assign seventh_out_freq_sel = output_config_four[POS_SEVENTH_SEL +: 4];
    assign pulse_2k_out_en = output_config_four[POS_PULSE_2K_EN];
    assign pulse_8k_out_en = output_config_four[POS_PULSE_8K_EN];
    assign t1e1_clk_out_en = output_config_four[POS_T1E1_EN];
    assign composite_clk_out_en = output_config_four[POS_COMPOSITE_EN];
    assign auto_squelch_en = aux_pll_config_one[POS_AUTO_SQUELCH];
    assign composite_duty_sel = aux_pll_config_one[POS_COMPOSITE_DUTY];
    assign t1e1_rate_sel = aux_pll_config_one[POS_T1E1_RATE];
    assign aux_dpll_freq_sel = aux_pll_config_one[POS_AUX_FREQ +: 4];
    assign aux_measure_main_phase = main_pll_config_one[POS_MEASURE];
    assign aux_apll_from_main = main_pll_config_one[POS_APLL_FROM_MAIN];
    assign main_to_aux_freq_sel = main_pll_config_one[POS_MAIN_TO_AUX +: 3];
    assign main_dpll_freq_sel = main_pll_config_one[POS_MAIN_FREQ +: 3];

    // apb phases; zero wait states so every access completes at once
    assign setup_phase = psel_in && !penable_in;
    assign access_phase = psel_in && penable_in;
    assign word_idx = {2'b00, paddr_in[ADDR_W-1:2]};
    assign hit_four = (word_idx == IDX_OUTPUT_CONFIG_FOUR);
    assign hit_aux = (word_idx == IDX_AUX_PLL_CONFIG_ONE);
    assign hit_main = (word_idx == IDX_MAIN_PLL_CONFIG_ONE);
    assign addr_hit = (hit_four || hit_aux || hit_main) && (paddr_in[1:0] == 2'b00);
    assign pready_out = 1'b1;
    assign pslverr_out = access_phase && !addr_hit;

    // read mux; unmapped words read zero
    always_comb
    begin
        read_byte = 8'h00;
        if (hit_four)
        begin
            read_byte = output_config_four;
        end
        else if (hit_aux)
        begin
            read_byte = aux_pll_config_one & MASK_AUX_PLL_CONFIG_ONE;
        end
        else if (hit_main)
        begin
            read_byte = main_pll_config_one;
        end
    end

    // read data captured in setup so it is stable through access
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            prdata_out <= 32'h00000000;
        end
        else if (ce_in && setup_phase && !pwrite_in)
        begin
            prdata_out <= {24'h000000, addr_hit ? read_byte : 8'h00};
        end
    end

    // agreed strap level, so a short reset already loads the settled pin
    assign next_strap_level = (strap_s2 == strap_s3) ? strap_s3 : strap_level;

    // three-stage strap sync, no reset so the pin reaches us during reset
    always_ff @(posedge sys_clk_in)
    begin
        if (ce_in)
        begin
            strap_meta <= rate_strap_in;
            strap_s2 <= strap_meta;
            strap_s3 <= strap_s2;
            strap_level <= next_strap_level;
        end
    end

    // output configuration register
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            output_config_four <= RST_OUTPUT_CONFIG_FOUR;
        end
        else if (ce_in && access_phase && pwrite_in && addr_hit && hit_four)
        begin
            output_config_four <= pwdata_in[7:0];
        end
    end

    // aux pll register; rate bit reloads from the strap every reset cycle with ce_in high
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            if (ce_in)
            begin
                aux_pll_config_one <= RST_AUX_PLL_CONFIG_ONE;
                aux_pll_config_one[POS_T1E1_RATE] <= next_strap_level;
            end
        end
        else if (ce_in && access_phase && pwrite_in && addr_hit && hit_aux)
        begin
            aux_pll_config_one <= pwdata_in[7:0] & MASK_AUX_PLL_CONFIG_ONE;
        end
    end

    // main pll register
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            main_pll_config_one <= RST_MAIN_PLL_CONFIG_ONE;
        end
        else if (ce_in && access_phase && pwrite_in && addr_hit && hit_main)
        begin
            main_pll_config_one <= pwdata_in[7:0];
        end
    end

    // one decoder per general output, differing only in two codes
    out_sel_decode #(.IS_SEVENTH(1'b0)) fifth_dec (
        .code_in(fifth_out_freq_sel),
        .src_out(fifth_src),
        .div_out(fifth_div)
    );

    out_sel_decode #(.IS_SEVENTH(1'b1)) seventh_dec (
        .code_in(seventh_out_freq_sel),
        .src_out(seventh_src),
        .div_out(seventh_div)
    );

    // aux dpll rates; unused codes behave as disabled
    always_comb
    begin
        case (aux_dpll_freq_sel)
            4'h1: aux_khz = KHZ_77760;
            4'h2: aux_khz = KHZ_24576;
            4'h3: aux_khz = KHZ_32768;
            4'h4: aux_khz = KHZ_37056;
            4'h5: aux_khz = KHZ_24704;
            4'h6: aux_khz = KHZ_68736;
            4'h7: aux_khz = KHZ_44736;
            4'h8: aux_khz = KHZ_25248;
            4'h9: aux_khz = KHZ_62500;
            default: aux_khz = KHZ_OFF;
        endcase
    end

    // rate fed from main dpll to the aux apll, independent of main rate
    always_comb
    begin
        case (main_to_aux_freq_sel)
            3'h0: m2a_khz = KHZ_24576;
            3'h2: m2a_khz = KHZ_32768;
            3'h4: m2a_khz = KHZ_37056;
            3'h6: m2a_khz = KHZ_24704;
            3'h7: m2a_khz = KHZ_25248;
            default: m2a_khz = KHZ_OFF;
        endcase
    end

    // main dpll rate; the two 77.76 codes differ only in feedback
    always_comb
    begin
        case (main_dpll_freq_sel)
            3'h0: main_khz = KHZ_77760;
            3'h1: main_khz = KHZ_77760;
            3'h2: main_khz = KHZ_24576;
            3'h3: main_khz = KHZ_32768;
            3'h4: main_khz = KHZ_37056;
            3'h5: main_khz = KHZ_24704;
            3'h6: main_khz = KHZ_25248;
            default: main_khz = KHZ_OFF;
        endcase
    end

    // measure mode takes the aux phase detector away from the loop
    assign aux_path_on = !aux_measure_main_phase && (aux_khz != KHZ_OFF);

    // squelch only applies while the aux dpll is the source
    assign squelch = !composite_t1e1_source_sel_in && auto_squelch_en
        && !aux_ref_valid_in;

    // main register rate bit overrides when the main path sources
    assign t1e1_rate_eff = composite_t1e1_source_sel_in ? main_rate_sel_in
        : t1e1_rate_sel;

    // gated fixed rate outputs, registered to keep the pins glitch free
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            pulse_2k_out <= 1'b0;
            pulse_8k_out <= 1'b0;
            t1e1_clk_out <= 1'b0;
            composite_clk_out <= 1'b0;
            composite_clk_oe_out <= 1'b0;
        end
        else if (ce_in)
        begin
            pulse_2k_out <= pulse_2k_out_en && pulse_2k_in;
            pulse_8k_out <= pulse_8k_out_en && pulse_8k_in;
            t1e1_clk_out <= t1e1_clk_out_en && !squelch && t1e1_clk_in;
            // disabled composite floats, squelched composite drives low
            composite_clk_oe_out <= composite_clk_out_en;
            composite_clk_out <= composite_clk_out_en && !squelch
                && composite_clk_in;
        end
    end

    // rate and duty selections toward the fixed rate generators
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            t1e1_rate_out <= 1'b0;
            composite_duty_out <= 1'b0;
        end
        else if (ce_in)
        begin
            t1e1_rate_out <= t1e1_rate_eff;
            composite_duty_out <= composite_duty_sel;
        end
    end

    // general output selections
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            fifth_src_out <= SRC_LOW;
            fifth_div_out <= 7'h01;
            seventh_src_out <= SRC_LOW;
            seventh_div_out <= 7'h01;
        end
        else if (ce_in)
        begin
            fifth_src_out <= fifth_src;
            fifth_div_out <= fifth_div;
            seventh_src_out <= seventh_src;
            seventh_div_out <= seventh_div;
        end
    end

    // aux pll settings; apll follows main when told, else four times aux
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            aux_dpll_en_out <= 1'b0;
            aux_measure_out <= 1'b0;
            aux_apll_from_main_out <= 1'b0;
            aux_dpll_khz_out <= KHZ_OFF;
            aux_apll_khz_out <= KHZ_OFF;
        end
        else if (ce_in)
        begin
            aux_dpll_en_out <= aux_path_on;
            aux_measure_out <= aux_measure_main_phase;
            aux_apll_from_main_out <= aux_apll_from_main;
            aux_dpll_khz_out <= aux_path_on ? aux_khz : KHZ_OFF;
            if (aux_apll_from_main)
            begin
                aux_apll_khz_out <= m2a_khz << APLL_SHIFT;
            end
            else if (aux_path_on)
            begin
                aux_apll_khz_out <= aux_khz << APLL_SHIFT;
            end
            else
            begin
                aux_apll_khz_out <= KHZ_OFF;
            end
        end
    end

    // main pll settings
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            main_dpll_en_out <= 1'b0;
            main_analog_fb_out <= 1'b0;
            main_dpll_khz_out <= KHZ_OFF;
            main_apll_khz_out <= KHZ_OFF;
        end
        else if (ce_in)
        begin
            main_dpll_en_out <= (main_khz != KHZ_OFF);
            main_analog_fb_out <= (main_dpll_freq_sel == 3'h1);
            main_dpll_khz_out <= main_khz;
            main_apll_khz_out <= main_khz << APLL_SHIFT;
        end
    end

endmodule : output_clock_select_config

//--- core/clk_sel_pkg.sv
// shared constants and types for the output clock selection block
package clk_sel_pkg;

    // apb geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_OUTPUT_CONFIG_FOUR = 12'h063;
    localparam logic [ADDR_W-1:0] IDX_AUX_PLL_CONFIG_ONE = 12'h064;
    localparam logic [ADDR_W-1:0] IDX_MAIN_PLL_CONFIG_ONE = 12'h065;

    // reset values; bit 4 of the aux register comes from the strap
    localparam logic [7:0] RST_OUTPUT_CONFIG_FOUR = 8'hF6;
    localparam logic [7:0] RST_AUX_PLL_CONFIG_ONE = 8'h01;
    localparam logic [7:0] RST_MAIN_PLL_CONFIG_ONE = 8'h01;

    // writable bit masks; unused bits read zero
    localparam logic [7:0] MASK_AUX_PLL_CONFIG_ONE = 8'h7F;

    // output_config_four fields
    localparam int POS_PULSE_2K_EN = 7;
    localparam int POS_PULSE_8K_EN = 6;
    localparam int POS_T1E1_EN = 5;
    localparam int POS_COMPOSITE_EN = 4;
    localparam int POS_SEVENTH_SEL = 0;

    // aux_pll_config_one fields
    localparam int POS_AUTO_SQUELCH = 6;
    localparam int POS_COMPOSITE_DUTY = 5;
    localparam int POS_T1E1_RATE = 4;
    localparam int POS_AUX_FREQ = 0;

    // main_pll_config_one fields
    localparam int POS_MEASURE = 7;
    localparam int POS_APLL_FROM_MAIN = 6;
    localparam int POS_MAIN_TO_AUX = 3;
    localparam int POS_MAIN_FREQ = 0;

    // dpll frequencies in khz
    localparam int KHZ_W = 19;
    localparam logic [KHZ_W-1:0] KHZ_77760 = 19'h12FC0;
    localparam logic [KHZ_W-1:0] KHZ_24576 = 19'h06000;
    localparam logic [KHZ_W-1:0] KHZ_32768 = 19'h08000;
    localparam logic [KHZ_W-1:0] KHZ_37056 = 19'h090C0;
    localparam logic [KHZ_W-1:0] KHZ_24704 = 19'h06080;
    localparam logic [KHZ_W-1:0] KHZ_68736 = 19'h10C80;
    localparam logic [KHZ_W-1:0] KHZ_44736 = 19'h0AEC0;
    localparam logic [KHZ_W-1:0] KHZ_25248 = 19'h062A0;
    localparam logic [KHZ_W-1:0] KHZ_62500 = 19'h0F424;
    localparam logic [KHZ_W-1:0] KHZ_OFF = 19'h00000;

    // apll runs at dpll times four
    localparam int APLL_SHIFT = 2;

    // divider width for the general outputs
    localparam int DIV_W = 7;

    // source of a general output clock
    typedef enum logic [2:0] {
        SRC_LOW,
        SRC_2K,
        SRC_8K,
        SRC_SYNTH_TWO,
        SRC_SYNTH_ONE,
        SRC_MAIN_APLL,
        SRC_AUX_APLL
    } src_t;

endpackage : clk_sel_pkg

//--- core/out_sel_decode.sv
// decoder from a 4-bit output selector code to a source and divider
`timescale 1ns/1ps
module out_sel_decode
    import clk_sel_pkg::*;
#(
    parameter bit IS_SEVENTH = 1'b0
)
(
    // selector code
    input wire logic [3:0] code_in,
    // decoded choice
    output src_t src_out,
    output logic [DIV_W-1:0] div_out
);

    // two codes differ between the fifth and seventh outputs
    always_comb
    begin
        src_out = SRC_LOW;
        div_out = 7'h01;
        case (code_in)
            4'h0: src_out = SRC_LOW;
            4'h1: src_out = SRC_2K;
            4'h2: src_out = SRC_8K;
            4'h3: src_out = SRC_SYNTH_TWO;
            4'h4: src_out = IS_SEVENTH ? SRC_MAIN_APLL : SRC_SYNTH_ONE;
            4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA: src_out = SRC_MAIN_APLL;
            default: src_out = SRC_AUX_APLL;
        endcase
        // divider apart from the source, so the enum never takes a bare vector
        case (code_in)
            4'h4: div_out = IS_SEVENTH ? 7'h02 : 7'h01;
            4'h5, 4'hC: div_out = 7'h30;
            4'h6, 4'hD: div_out = 7'h10;
            4'h7: div_out = 7'h0C;
            4'h8, 4'hE: div_out = 7'h08;
            4'h9: div_out = 7'h06;
            4'hA, 4'hF: div_out = 7'h04;
            4'hB: div_out = IS_SEVENTH ? 7'h40 : 7'h02;
            default: div_out = 7'h01;
        endcase
    end

endmodule : out_sel_decode

//--- dv/clk_sel_monitor.sv
// port checker for the output clock selection block
`timescale 1ns/1ps
module clk_sel_monitor
    import clk_sel_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // apb
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic pslverr_out,
    input wire logic [DATA_W-1:0] prdata_out,
    // gated sources
    input wire logic pulse_2k_in,
    input wire logic pulse_2k_out,
    input wire logic t1e1_clk_in,
    input wire logic t1e1_clk_out,
    // selections and rates
    input wire src_t fifth_src_out,
    input wire logic [DIV_W-1:0] fifth_div_out,
    input wire logic aux_measure_out,
    input wire logic aux_apll_from_main_out,
    input wire logic [KHZ_W-1:0] aux_dpll_khz_out,
    input wire logic [KHZ_W-1:0] aux_apll_khz_out,
    input wire logic main_dpll_en_out,
    input wire logic main_analog_fb_out,
    input wire logic [KHZ_W-1:0] main_dpll_khz_out,
    input wire logic [KHZ_W-1:0] main_apll_khz_out
);
    // one domain, so one clocking and one disable
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    // error flag must match the decode, both ways
    a_err_map: assert property (psel_in && penable_in |->
        pslverr_out == !(paddr_in inside {12'h18C, 12'h190, 12'h194}))
        else $error("slave error flag wrong");
    a_rdata_top: assert property (prdata_out[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_fifth_half: assert property (fifth_div_out == 7'h02 |->
        fifth_src_out == SRC_AUX_APLL) else $error("fifth halved output not from aux apll");
    // the 2k copy can only be high, and the t1e1 copy only rise, if the source was high an edge earlier
    a_pulse_gate: assert property (pulse_2k_out |-> $past(pulse_2k_in))
        else $error("pulse output without source");
    a_t1e1_gate: assert property ($rose(t1e1_clk_out) |-> $past(t1e1_clk_in))
        else $error("t1e1 output without source");
    a_aux_four: assert property (!aux_apll_from_main_out && !aux_measure_out |->
        aux_apll_khz_out == aux_dpll_khz_out << 2) else $error("aux apll not four times");
    a_main_four: assert property (main_apll_khz_out == main_dpll_khz_out << 2)
        else $error("main apll not four times");
    a_main_en: assert property (main_dpll_en_out == (main_dpll_khz_out != KHZ_OFF))
        else $error("main enable disagrees with rate");
    a_analog_fb: assert property (main_analog_fb_out |-> main_dpll_khz_out == KHZ_77760)
        else $error("analog feedback at wrong rate");

    // main scenarios reached
    c_err: cover property (psel_in && penable_in && pslverr_out);
    c_from_main: cover property (aux_apll_from_main_out);
    c_analog: cover property (main_analog_fb_out);
endmodule : clk_sel_monitor

bind output_clock_select_config clk_sel_monitor u_mon (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .paddr_in(paddr_in), .pslverr_out(pslverr_out), .prdata_out(prdata_out),
    .pulse_2k_in(pulse_2k_in), .pulse_2k_out(pulse_2k_out), .t1e1_clk_in(t1e1_clk_in),
    .t1e1_clk_out(t1e1_clk_out), .fifth_src_out(fifth_src_out), .fifth_div_out(fifth_div_out),
    .aux_measure_out(aux_measure_out), .aux_apll_from_main_out(aux_apll_from_main_out),
    .aux_dpll_khz_out(aux_dpll_khz_out), .aux_apll_khz_out(aux_apll_khz_out),
    .main_dpll_en_out(main_dpll_en_out), .main_analog_fb_out(main_analog_fb_out),
    .main_dpll_khz_out(main_dpll_khz_out), .main_apll_khz_out(main_apll_khz_out));

//--- dv/output_clock_select_config_test.sv
// self-checking bench for the output clock selection block
`timescale 1ns/1ps
`define CHK(g, e) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("[ERR] %0t got %h exp %h", $time, g, e); \
    end \
end
module output_clock_select_config_test
    import clk_sel_pkg::*;
;
    // stimulus given a value at time zero, apart from err, rdata and ek
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, err;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata;
    logic strap = 1, srcsel = 0, mrate = 0, refok = 1, p2k = 1, p8k = 1, t1 = 1, cc = 1;
    logic ce = 1;
    logic [3:0] f5 = 4'h0;
    logic [KHZ_W-1:0] ek;
    // observed outputs
    logic pready, pslverr, p2k_o, p8k_o, t1_o, cc_o, cc_oe, rate_o, duty_o;
    logic aen, ameas, afm, men, mfb;
    logic [DATA_W-1:0] prdata;
    src_t src5, src7;
    logic [DIV_W-1:0] div5, div7;
    logic [KHZ_W-1:0] akhz, aapll, mkhz, mapll;
    int err_total = 0, n_tests = 0;
    // expected tables, unused codes read as off
    localparam logic [ADDR_W-1:0] A4 = 12'h18C, A5 = 12'h190, A6 = 12'h194;
    localparam logic [DIV_W-1:0] DIV7 [16] = '{1, 1, 1, 1, 2, 48, 16, 12, 8, 6, 4, 64, 48, 16,
        8, 4};
    localparam logic [KHZ_W-1:0] AUX_TAB [16] = '{1: KHZ_77760, 2: KHZ_24576, 3: KHZ_32768,
        4: KHZ_37056, 5: KHZ_24704, 6: KHZ_68736, 7: KHZ_44736, 8: KHZ_25248, 9: KHZ_62500,
        default: KHZ_OFF};
    localparam logic [KHZ_W-1:0] M2A [8] = '{0: KHZ_24576, 2: KHZ_32768, 4: KHZ_37056,
        6: KHZ_24704, 7: KHZ_25248, default: KHZ_OFF};
    localparam logic [KHZ_W-1:0] MAIN_TAB [8] = '{KHZ_77760, KHZ_77760, KHZ_24576, KHZ_32768,
        KHZ_37056, KHZ_24704, KHZ_25248, KHZ_OFF};

    // 50 ns clock
    always #25 clk = ~clk;

    // every input comes from the bench, clock enable included
    output_clock_select_config uut (
        .sys_clk_in(clk), .rst_in(rst), .ce_in(ce), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wdata), .pready_out(pready),
        .pslverr_out(pslverr), .prdata_out(prdata), .rate_strap_in(strap),
        .composite_t1e1_source_sel_in(srcsel), .main_rate_sel_in(mrate),
        .fifth_out_freq_sel_in(f5),
        .aux_ref_valid_in(refok), .pulse_2k_in(p2k), .pulse_8k_in(p8k), .t1e1_clk_in(t1),
        .composite_clk_in(cc), .pulse_2k_out(p2k_o), .pulse_8k_out(p8k_o),
        .t1e1_clk_out(t1_o), .composite_clk_out(cc_o), .composite_clk_oe_out(cc_oe),
        .t1e1_rate_out(rate_o), .composite_duty_out(duty_o), .fifth_src_out(src5),
        .fifth_div_out(div5), .seventh_src_out(src7), .seventh_div_out(div7),
        .aux_dpll_en_out(aen), .aux_measure_out(ameas), .aux_apll_from_main_out(afm),
        .aux_dpll_khz_out(akhz), .aux_apll_khz_out(aapll), .main_dpll_en_out(men),
        .main_analog_fb_out(mfb), .main_dpll_khz_out(mkhz), .main_apll_khz_out(mapll));

    // one apb transfer; waits for pready, takes data at that edge
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdata <= {24'h000000, d};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : xfer

    // registered outputs land one edge after the register
    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        settle;
    endtask : do_reset

    function automatic src_t exp7(input int c);
        return c == 0 ? SRC_LOW : c == 1 ? SRC_2K : c == 2 ? SRC_8K : c == 3 ? SRC_SYNTH_TWO :
            c < 11 ? SRC_MAIN_APLL : SRC_AUX_APLL;
    endfunction : exp7

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #500000;
        err_total++;
        wrap_up;
    end

    // main sequence
    initial
    begin
        do_reset;
        xfer(0, A4, 0);
        `CHK(rdata[7:0], RST_OUTPUT_CONFIG_FOUR)
        xfer(0, A5, 0);
        `CHK(rdata[7:0], 8'h11)
        xfer(0, A6, 0);
        `CHK(rdata[7:0], RST_MAIN_PLL_CONFIG_ONE)
        `CHK({src5, div5, src7, div7}, {SRC_LOW, 7'h01, SRC_MAIN_APLL, 7'h10})
        `CHK({cc_oe, rate_o}, 2'b11)
        for (int c = 0; c < 16; c++)
        begin
            xfer(1, A4, {4'hF, c[3:0]});
            f5 <= c[3:0];
            settle;
            `CHK(src7, exp7(c))
            if (c > 3) `CHK(div7, DIV7[c])
            `CHK(src5, c == 4 ? SRC_SYNTH_ONE : exp7(c))
            `CHK(div5, c == 4 ? 7'h01 : c == 11 ? 7'h02 : DIV7[c])
        end
        for (int b = 4; b < 8; b++)
        begin
            xfer(1, A4, 8'h01 << b);
            settle;
            `CHK({p2k_o, p8k_o, t1_o, cc_oe}, 4'b0001 << (b - 4))
        end
        // squelch only while the aux path sources the outputs
        xfer(1, A4, 8'hF0);
        xfer(1, A5, 8'h60);
        refok <= 1'b0;
        settle;
        `CHK({t1_o, cc_o, cc_oe, duty_o, rate_o}, 5'b00110)
        @(posedge clk);
        srcsel <= 1'b1;
        mrate <= 1'b1;
        settle;
        `CHK({t1_o, cc_o, rate_o}, 3'b111)
        @(posedge clk);
        refok <= 1'b1;
        srcsel <= 1'b0;
        p2k <= 1'b0;
        settle;
        `CHK({t1_o, cc_o, rate_o, p2k_o}, 4'b1100)
        xfer(1, A5, 8'hFF);
        xfer(0, A5, 0);
        `CHK(rdata[7:0], MASK_AUX_PLL_CONFIG_ONE)
        xfer(1, 12'h198, 8'h55);
        `CHK(err, 1'b1)
        xfer(0, 12'h18D, 0);
        `CHK({err, rdata}, {1'b1, 32'h00000000})
        // a low enable must drop the write
        ce <= 1'b0;
        xfer(1, A6, 8'h07);
        ce <= 1'b1;
        xfer(0, A6, 0);
        `CHK(rdata[7:0], RST_MAIN_PLL_CONFIG_ONE)
        for (int c = 0; c < 16; c++)
        begin
            xfer(1, A5, {4'h0, c[3:0]});
            ek = AUX_TAB[c];
            settle;
            `CHK({aen, akhz, aapll}, {ek != KHZ_OFF, ek, ek << 2})
        end
        xfer(1, A6, 8'h81);
        xfer(1, A5, 8'h01);
        settle;
        `CHK({ameas, aen, akhz}, {2'b10, KHZ_OFF})
        for (int t = 0; t < 8; t++)
        begin
            xfer(1, A6, {2'b01, t[2:0], 3'b001});
            settle;
            `CHK({afm, aapll}, {1'b1, M2A[t] << 2})
        end
        for (int c = 0; c < 8; c++)
        begin
            xfer(1, A6, {5'h00, c[2:0]});
            ek = MAIN_TAB[c];
            settle;
            `CHK({men, mfb, mkhz, mapll}, {ek != KHZ_OFF, c == 1, ek, ek << 2})
        end
        // second reset with the strap low
        @(posedge clk);
        strap <= 1'b0;
        settle;
        do_reset;
        xfer(0, A5, 0);
        `CHK({rdata[7:0], rate_o}, {RST_AUX_PLL_CONFIG_ONE, 1'b0})
        wrap_up;
    end
endmodule : output_clock_select_config_test
